// ### hdl/ctm_pkg.sv
// Constants for the compact timer: register indices, field positions, reset values.
// Assumes a byte-wide register port with one-cycle read latency.
package ctm_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [2:0] ADDR_CTRL_FIRST   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_SECOND  = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LOW    = 3'h2;
  localparam logic [2:0] ADDR_COUNT_HIGH   = 3'h3;
  localparam logic [2:0] ADDR_MATCH_A_LOW  = 3'h4;
  localparam logic [2:0] ADDR_MATCH_A_HIGH = 3'h5;

  // ****************************************
  // Field positions in control registers
  // ****************************************
  localparam int PAUSE_BIT     = 7;
  localparam int CLK_SEL_LSB   = 4;
  localparam int ON_BIT        = 3;
  localparam int PERIOD_LSB    = 0;
  localparam int MODE_LSB      = 6;
  localparam int ACTION_LSB    = 4;
  localparam int INIT_LVL_BIT  = 3;
  localparam int POLARITY_BIT  = 2;
  localparam int CLR_SRC_BIT   = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] CLK_SYS_DIV4   = 3'h0;
  localparam logic [2:0] CLK_SYS        = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SUB_A      = 3'h4;
  localparam logic [2:0] CLK_SUB_B      = 3'h5;
  localparam logic [2:0] CLK_SINE_RISE  = 3'h6;
  localparam logic [2:0] CLK_SINE_FALL  = 3'h7;

  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_UNDEF   = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // ****************************************
  // Prescaler divide ratios
  // ****************************************
  localparam int DIV_SYS4   = 4;
  localparam int DIV_HIGH16 = 16;
  localparam int DIV_HIGH64 = 64;

endpackage

// ### hdl/ctm_edge_sync.sv
// Three-stage synchroniser with edge detection for one asynchronous input.
// Assumes the input changes slower than two core clock periods.
`timescale 1ns/1ps

module ctm_edge_sync (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      rise_o,
  output logic      fall_o
);

  logic [2:0] stage;
  logic       settled;
  logic       next_settled;

  // A change counts once stages two and three agree
  assign next_settled = (stage[2] == stage[1]) ? stage[2] : settled;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage   <= 3'h0;
      settled <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      stage   <= {stage[1:0], async_i};
      settled <= next_settled;
      rise_o  <= next_settled & ~settled;
      fall_o  <= ~next_settled & settled;
    end
  end

endmodule

// ### hdl/ctm_timer.sv
// Compact 10-bit count-up timer with byte-wide register file and shared low-byte buffer.
// Assumes one core clock, prescaled tick enables from the core clock, sine edge asynchronous.
// Functional notes
// - Writing compare-A low byte only loads the shared holding buffer.
// - Writing compare-A high byte stores it and copies buffer into low byte.
// - Reading a high byte returns it and captures matching low byte into buffer.
// - Reading a low byte returns the holding buffer contents.
// - Ten-bit up-counter advances per selected tick while on and not paused.
// - Comparator P checks all ten counter bits against period times 128 less one; comparator A checks all ten bits.
// - Counter clears itself on overflow or selected match; no software write.
// - Comparator A match, or P match or overflow with clear-source zero, raises a timer interrupt request.
// - Pause bit halts counting and holds count; clearing resumes.
// - Clock select picks sys/4, sys, high/16, high/64, sub, sine rise or fall.
// - Event counting input is the sine generator edge signal.
// - On bit runs counter; off stops it and enters low-power state.
// - Rising on bit clears counter; falling keeps residual count.
// - Rising on bit forces output to initial level in compare and PWM modes.
// - Period field gives P match at multiples of 128; zero means 1024 overflow.
// - Clear-source zero lets comparator P match reset the counter.
// - Mode field: 00 compare, 01 undefined, 10 PWM, 11 timer/counter.
// - Output level is undefined in timer/counter mode.
// - Clear-source one lets comparator A match reset the counter instead.
// - Compare mode action on A match: none, low, high, toggle.
// - Output-control bit gives output level before any compare match.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps

module ctm_timer #(
  parameter int CNT_WIDTH = 10
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       high_clk_tick_i,
  input  wire logic       sub_clk_tick_i,
  input  wire logic       sine_edge_signal_i,
  output logic            match_a_flag_o,
  output logic            match_p_flag_o,
  output logic            timer_out_o,
  output logic            timer_on_o
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0]           ctrl_first;
  logic [7:0]           ctrl_second;
  logic [7:0]           hold_buf;
  logic [7:0]           match_a_low;
  logic [1:0]           match_a_high;
  logic [CNT_WIDTH-1:0] count;
  logic                 on_prev;
  logic                 out_level;

  // ****************************************
  // Strobe and field decode
  // ****************************************

  wire wr_ctrl0  = reg_wr_i && (reg_addr_i == ctm_pkg::ADDR_CTRL_FIRST);
  wire wr_ctrl1  = reg_wr_i && (reg_addr_i == ctm_pkg::ADDR_CTRL_SECOND);
  wire wr_a_low  = reg_wr_i && (reg_addr_i == ctm_pkg::ADDR_MATCH_A_LOW);
  wire wr_a_high = reg_wr_i && (reg_addr_i == ctm_pkg::ADDR_MATCH_A_HIGH);
  wire rd_c_high = reg_rd_i && (reg_addr_i == ctm_pkg::ADDR_COUNT_HIGH);
  wire rd_a_high = reg_rd_i && (reg_addr_i == ctm_pkg::ADDR_MATCH_A_HIGH);

  wire       pause_ctl            = ctrl_first[ctm_pkg::PAUSE_BIT];
  wire [2:0] count_clock_sel      = ctrl_first[ctm_pkg::CLK_SEL_LSB +: 3];
  wire       counter_on           = ctrl_first[ctm_pkg::ON_BIT];
  wire [2:0] period_compare_value = ctrl_first[ctm_pkg::PERIOD_LSB +: 3];
  wire [1:0] op_mode_sel          = ctrl_second[ctm_pkg::MODE_LSB +: 2];
  wire [1:0] out_action_sel       = ctrl_second[ctm_pkg::ACTION_LSB +: 2];
  wire       out_initial_level    = ctrl_second[ctm_pkg::INIT_LVL_BIT];
  wire       out_polarity         = ctrl_second[ctm_pkg::POLARITY_BIT];
  wire       clear_source_sel     = ctrl_second[ctm_pkg::CLR_SRC_BIT];

  wire [9:0] compare_a_reg = {match_a_high, match_a_low};

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr_i)
      ctm_pkg::ADDR_CTRL_FIRST:   rd_mux = ctrl_first;
      ctm_pkg::ADDR_CTRL_SECOND:  rd_mux = ctrl_second;
      ctm_pkg::ADDR_COUNT_LOW:    rd_mux = hold_buf;
      ctm_pkg::ADDR_COUNT_HIGH:   rd_mux = {6'h00, count[9:8]};
      ctm_pkg::ADDR_MATCH_A_LOW:  rd_mux = hold_buf;
      ctm_pkg::ADDR_MATCH_A_HIGH: rd_mux = {6'h00, match_a_high};
      default:                    rd_mux = 8'h00;
    endcase
  end

  // Buffer is shared: interleaving two pair accesses corrupts the one begun first
  wire [7:0] next_hold_buf = wr_a_low  ? reg_wdata_i :
                             rd_c_high ? count[7:0] :
                             rd_a_high ? match_a_low : hold_buf;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_first <= ctm_pkg::CTRL_RESET;
    end else if (wr_ctrl0) begin
      ctrl_first <= reg_wdata_i;
    end
  end

  // Mode changes while running are the user's risk; no interlock here
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_second <= ctm_pkg::CTRL_RESET;
    end else if (wr_ctrl1) begin
      ctrl_second <= reg_wdata_i;
    end
  end

  // ****************************************
  // Compare-A pair and holding buffer
  // ****************************************
  // Both halves move together so the comparator never sees a torn value
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      match_a_high <= 2'h0;
      match_a_low  <= 8'h00;
    end else if (wr_a_high) begin
      match_a_high <= reg_wdata_i[1:0];
      match_a_low  <= hold_buf;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_buf <= 8'h00;
    end else begin
      hold_buf <= next_hold_buf;
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  // Zero outside the answer cycle so a stale byte never looks valid
  wire [7:0] next_rdata = reg_rd_i ? rd_mux : 8'h00;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ****************************************
  // Prescaler and tick selection
  // ****************************************
  logic [5:0] sys_div;
  logic [5:0] high_div;
  logic       sine_rise;
  logic       sine_fall;

  // ****************************************
  // Sine edge synchroniser
  // ****************************************
  ctm_edge_sync u_sine_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    (sine_edge_signal_i),
    .rise_o     (sine_rise),
    .fall_o     (sine_fall)
  );

  // ****************************************
  // Divided ticks
  // ****************************************
  wire tick_sys4   = (sys_div[1:0] == 2'(ctm_pkg::DIV_SYS4 - 1));
  wire tick_high16 = high_clk_tick_i && (high_div[3:0] == 4'(ctm_pkg::DIV_HIGH16 - 1));
  wire tick_high64 = high_clk_tick_i && (high_div == 6'(ctm_pkg::DIV_HIGH64 - 1));

  // ****************************************
  // Tick selection
  // ****************************************
  logic tick;

  always_comb begin
    tick = 1'b0;
    unique case (count_clock_sel)
      ctm_pkg::CLK_SYS_DIV4:   tick = tick_sys4;
      ctm_pkg::CLK_SYS:        tick = 1'b1;
      ctm_pkg::CLK_HIGH_DIV16: tick = tick_high16;
      ctm_pkg::CLK_HIGH_DIV64: tick = tick_high64;
      ctm_pkg::CLK_SUB_A:      tick = sub_clk_tick_i;
      ctm_pkg::CLK_SUB_B:      tick = sub_clk_tick_i;
      ctm_pkg::CLK_SINE_RISE:  tick = sine_rise;
      ctm_pkg::CLK_SINE_FALL:  tick = sine_fall;
    endcase
  end

  // ****************************************
  // Prescalers
  // ****************************************
  // Dividers idle while off to save power
  wire [5:0] next_sys_div  = counter_on ? sys_div + 6'h01 : 6'h00;
  wire [5:0] next_high_div = !counter_on     ? 6'h00 :
                             high_clk_tick_i ? high_div + 6'h01 : high_div;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sys_div <= 6'h00;
    end else begin
      sys_div <= next_sys_div;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_div <= 6'h00;
    end else begin
      high_div <= next_high_div;
    end
  end

  // ****************************************
  // Counter and comparators
  // ****************************************
  wire run     = counter_on && !pause_ctl && tick;
  wire on_rise = counter_on && !on_prev;

  // ****************************************
  // Match detection
  // ****************************************
  // Match is taken on the tick that would step the count onto the compare value
  wire p_match = (period_compare_value != 3'h0) &&
                 (count == {period_compare_value, 7'h00} - 10'h001);
  wire a_match = (compare_a_reg != 10'h000) &&
                 (count == compare_a_reg - 10'h001);
  wire ovf     = (count == 10'h3FF);

  wire p_event = run && !clear_source_sel && (p_match || ovf);
  wire a_event = run && a_match;
  wire clr     = clear_source_sel ? (run && (a_match || ovf)) : p_event;

  wire [9:0] next_count = on_rise ? 10'h000 :
                          clr     ? 10'h000 :
                          run     ? count + 10'h001 : count;

  // ****************************************
  // Output level
  // ****************************************
  wire comp_mode = (op_mode_sel == ctm_pkg::MODE_COMPARE) ||
                   (op_mode_sel == ctm_pkg::MODE_PWM);

  logic next_out;

  always_comb begin
    next_out = out_level;
    if (on_rise && comp_mode) begin
      next_out = out_initial_level;
    end else if (op_mode_sel == ctm_pkg::MODE_COMPARE && a_event) begin
      unique case (out_action_sel)
        ctm_pkg::ACT_NONE:   next_out = out_level;
        ctm_pkg::ACT_LOW:    next_out = 1'b0;
        ctm_pkg::ACT_HIGH:   next_out = 1'b1;
        ctm_pkg::ACT_TOGGLE: next_out = ~out_level;
      endcase
    end
  end

  // ****************************************
  // Counter state
  // ****************************************
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 10'h000;
    end else begin
      count <= next_count;
    end
  end

  // Edge memory for the on bit; reset matches the off state
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      on_prev <= 1'b0;
    end else begin
      on_prev <= counter_on;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_level <= 1'b0;
    end else begin
      out_level <= next_out;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Flags are one-cycle requests; the interrupt logic outside holds them
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      match_a_flag_o <= 1'b0;
    end else begin
      match_a_flag_o <= a_event;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      match_p_flag_o <= 1'b0;
    end else begin
      match_p_flag_o <= p_event;
    end
  end

  // Timer mode output carries no meaning; held low here
  wire next_timer_out = (op_mode_sel == ctm_pkg::MODE_TIMER) ? 1'b0 :
                        (next_out ^ out_polarity);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_out_o <= 1'b0;
    end else begin
      timer_out_o <= next_timer_out;
    end
  end

  // Lets the power manager see when the block may be gated
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_on_o <= 1'b0;
    end else begin
      timer_on_o <= counter_on;
    end
  end

endmodule

// ### dv/ctm_chk.sv
// Port checker for the compact timer.
// Assumes it is bound to ctm_timer; it shadows the control writes itself.
`timescale 1ns/1ps
module ctm_chk #(
  parameter int CNT_WIDTH = 10
) (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       match_a_flag_o,
  input wire logic       match_p_flag_o,
  input wire logic       timer_out_o,
  input wire logic       timer_on_o
);
  logic [7:0] ctl_a;
  logic [7:0] ctl_b;
  wire        idle  = !ctl_a[3] || ctl_a[7];
  wire        hi_rd = reg_addr_i == 3'h3 || reg_addr_i == 3'h5;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_a <= 8'h00;
      ctl_b <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == 3'h0) begin
      ctl_a <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 3'h1) begin
      ctl_b <= reg_wdata_i;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  high_bits_a: assert property ($past(reg_rd_i) && $past(hi_rd) |-> reg_rdata_o[7:2] == 6'h00)
    else $error("high byte upper bits set");
  on_copy_a: assert property (reg_wr_i && reg_addr_i == 3'h0 |->
    ##2 timer_on_o == $past(reg_wdata_i[3], 2))
    else $error("on indicator wrong");
  p_only_a: assert property (match_p_flag_o |-> !$past(ctl_b[0]))
    else $error("p flag with clear source a");
  quiet_a: assert property (idle [*3] |-> !match_p_flag_o && !match_a_flag_o)
    else $error("flag while stopped");
  p_pulse_a: assert property (match_p_flag_o |=> !match_p_flag_o)
    else $error("p flag too long");
  a_pulse_a: assert property (match_a_flag_o |=> !match_a_flag_o)
    else $error("a flag too long");
  init_lvl_a: assert property ($rose(timer_on_o) && ctl_b[7:6] == 2'h0 |->
    ##[0:2] timer_out_o == (ctl_b[3] ^ ctl_b[2]))
    else $error("output not at initial level");
endmodule

// ### dv/ctm_far_model.sv
// Far-side sources: high and sub clock ticks and the sine edge level.
// Assumes the core clock; the sine level also toggles on core clock edges.
`timescale 1ns/1ps
module ctm_far_model #(
  parameter int HIGH_PER  = 2,
  parameter int SUB_PER   = 4,
  parameter int SINE_HALF = 8
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  output logic      high_tick_o,
  output logic      sub_tick_o,
  output logic      sine_o
);
  int cnt;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt         <= 0;
      high_tick_o <= 1'b0;
      sub_tick_o  <= 1'b0;
      sine_o      <= 1'b0;
    end else begin
      cnt         <= cnt + 1;
      high_tick_o <= cnt % HIGH_PER == 0;
      sub_tick_o  <= cnt % SUB_PER == 0;
      if (cnt % SINE_HALF == 0) sine_o <= !sine_o;
    end
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the compact timer registers and counter.
// Assumes ticks and sine level come from the far model on the core clock.
`timescale 1ns/1ps
module tb_top;
  logic       clk;
  logic       rst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       h_tick;
  logic       s_tick;
  logic       sine;
  logic       fa;
  logic       fp;
  logic       tout;
  logic       ton;
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;

  ctm_timer DUT (.core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .high_clk_tick_i(h_tick),
    .sub_clk_tick_i(s_tick), .sine_edge_signal_i(sine), .match_a_flag_o(fa),
    .match_p_flag_o(fp), .timer_out_o(tout), .timer_on_o(ton));
  ctm_far_model far (.core_clk_i(clk), .reset_i(rst), .high_tick_o(h_tick),
    .sub_tick_o(s_tick), .sine_o(sine));

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_cnt(output logic [9:0] c);
    logic [7:0] h;
    logic [7:0] l;
    rd_reg(3'h3, h);
    rd_reg(3'h2, l);
    c = {h[1:0], l};
  endtask
  // Bounded so a dead comparator cannot hang the run
  task automatic wait_flag(input bit pick_a, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((pick_a ? fa : fp) !== 1'b1 && n < 2000);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    logic [9:0] c;
    rd_reg(3'h0, d);
    check("ctrl_first", 16'(d), 16'h0000);
    rd_reg(3'h1, d);
    check("ctrl_second", 16'(d), 16'h0000);
    wr_reg(3'h2, 8'hFF);
    wr_reg(3'h3, 8'hFF);
    wr_reg(3'h7, 8'hFF);
    rd_reg(3'h7, d);
    check("unmapped", 16'(d), 16'h0000);
    rd_cnt(c);
    check("count_ro", 16'(c), 16'h0000);
  endtask
  task automatic t_pair();
    logic [7:0] d;
    wr_reg(3'h4, 8'h34);
    rd_reg(3'h5, d);
    rd_reg(3'h4, d);
    check("a_low_live", 16'(d), 16'h0000);
    wr_reg(3'h4, 8'h34);
    wr_reg(3'h5, 8'h02);
    rd_reg(3'h5, d);
    check("a_high", 16'(d), 16'h0002);
    rd_reg(3'h4, d);
    check("a_low", 16'(d), 16'h0034);
    wr_reg(3'h4, 8'h77);
    rd_reg(3'h4, d);
    check("buffer", 16'(d), 16'h0077);
  endtask
  task automatic t_period();
    int n;
    int pv [3] = '{1, 7, 0};
    foreach (pv[i]) begin
      wr_reg(3'h0, 8'h18 | 8'(pv[i]));
      wait_flag(1'b0, n);
      wait_flag(1'b0, n);
      check("p_period", 16'(n), 16'(pv[i] == 0 ? 1024 : 128 * pv[i]));
    end
  endtask
  task automatic t_pause();
    logic [9:0] a;
    logic [9:0] b;
    wr_reg(3'h0, 8'h98);
    rd_cnt(a);
    repeat (20) @(posedge clk);
    rd_cnt(b);
    check("paused", 16'(b), 16'(a));
    wr_reg(3'h0, 8'h18);
    repeat (20) @(posedge clk);
    rd_cnt(b);
    check("resumed", 16'(10'(b - a) >= 20 && 10'(b - a) <= 30), 16'h0001);
    wr_reg(3'h0, 8'h10);
    rd_cnt(a);
    check("on_ind_off", 16'(ton), 16'h0000);
    repeat (10) @(posedge clk);
    rd_cnt(b);
    check("residual", 16'(b), 16'(a));
    wr_reg(3'h0, 8'h18);
    rd_cnt(b);
    check("restart", 16'(b < 10'h008), 16'h0001);
    check("on_ind_on", 16'(ton), 16'h0001);
  endtask
  task automatic t_clear_a();
    int n;
    logic o;
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h1, 8'h31);
    wr_reg(3'h4, 8'h0A);
    wr_reg(3'h5, 8'h00);
    wr_reg(3'h0, 8'h18);
    wait_flag(1'b1, n);
    wait_flag(1'b1, n);
    check("a_period", 16'(n), 16'h000A);
    #20 o = tout;
    wait_flag(1'b1, n);
    #20 check("toggle", 16'(tout), 16'(!o));
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h1, 8'h00);
  endtask
  task automatic t_modes();
    int n;
    for (int k = 0; k < 2; k++) begin
      wr_reg(3'h0, 8'h10);
      wr_reg(3'h1, k == 0 ? 8'h80 : 8'h88);
      wr_reg(3'h0, 8'h18);
      @(posedge clk);
      #1 check("pwm_init", 16'(tout), 16'(k));
    end
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h1, 8'hC1);
    wr_reg(3'h0, 8'h18);
    wait_flag(1'b1, n);
    wait_flag(1'b1, n);
    check("timer_mode", 16'(n), 16'h000A);
    wr_reg(3'h0, 8'h10);
    wr_reg(3'h1, 8'h00);
  endtask
  task automatic t_clk_sel();
    logic [9:0] c;
    int per [8] = '{4, 1, 32, 128, 4, 4, 16, 16};
    for (int s = 0; s < 8; s++) begin
      wr_reg(3'h0, 8'(s << 4));
      wr_reg(3'h0, 8'(s << 4) | 8'h08);
      repeat (256) @(posedge clk);
      rd_cnt(c);
      check("clk_sel", 16'(int'(c) > 256 / per[s] - 3 && int'(c) < 256 / per[s] + 6), 16'h0001);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    rst   = 1'b1;
    addr  = 3'h0;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pair();
    t_period();
    t_pause();
    t_clear_a();
    t_modes();
    t_clk_sel();
    end_of_test();
  end
endmodule

bind ctm_timer ctm_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o),
  .timer_out_o(timer_out_o), .timer_on_o(timer_on_o));
